// *** logic/tslm_top.v ***
// Time-slot list manager: AHB-Lite command port, six slot lists, highway slot engine
`include "tslm_consts.vh"
module tslm_top (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // Highway pins
  input  wire        highway_bit_clock,
  input  wire        highway_frame_sync,
  input  wire        highway_rx_data,
  output reg         highway_tx_data,
  output reg         highway_tx_oe,
  // Received slot words
  output reg         rx_valid,
  output reg  [31:0] rx_word,
  output reg  [4:0]  rx_pipe,
  output reg         rx_mon_valid,
  output reg  [4:0]  rx_mon_pipe
);

  integer i;

  // Descriptor store, one entry per pipe and direction
  reg [31:0] in_desc   [0:31]; // Incoming descriptors
  reg [31:0] out_desc  [0:31]; // Outgoing descriptors
  reg [1:0]  in_if     [0:31]; // Interface list of each incoming entry
  reg [1:0]  out_if    [0:31]; // Interface list of each outgoing entry
  reg [31:0] fixed_data[0:15]; // Constant data of short pipes 16..31
  reg [31:0] in_ok;            // Incoming entry is in a list
  reg [31:0] out_ok;           // Outgoing entry is in a list
  reg [31:0] mon_on;           // Monitor link of an incoming entry

  // Software visible registers
  reg [31:0] arg_in;   // Incoming descriptor argument
  reg [31:0] arg_out;  // Outgoing descriptor or fixed data argument
  reg [1:0]  if_sel;   // Interface of the next define command
  reg [4:0]  query;    // Pipe shown by the query registers
  reg [7:0]  cmd_cnt;  // Commands taken
  reg [7:0]  rej_cnt;  // Commands ignored
  reg        last_rej; // Last command ignored

  // Bus pipeline
  reg        wr_pend;  // Write data phase pending
  reg        rd_pend;  // Read waits one cycle for settled state
  reg [7:0]  ph_addr;  // Latched word address

  // Highway timing
  wire       clk_s;    // Synchronised bit clock
  wire       fs_s;     // Synchronised frame sync
  wire       rxd_s;    // Synchronised receive data
  reg        clk_d;    // Previous bit clock for edge find
  reg        tick_d;   // Bit clock edge seen one cycle ago
  reg  [9:0] hw_count; // Highway bit count within frame
  wire       tick = clk_s && !clk_d;
  wire [9:0] count_now = fs_s ? 10'h000 : hw_count + 10'h001;

  tslm_sync u_sync_clk (.hclk(hclk), .hresetn(hresetn), .din(highway_bit_clock), .dout(clk_s));
  tslm_sync u_sync_fs  (.hclk(hclk), .hresetn(hresetn), .din(highway_frame_sync), .dout(fs_s));
  tslm_sync u_sync_rx  (.hclk(hclk), .hresetn(hresetn), .din(highway_rx_data), .dout(rxd_s));

  // Highway bit count, restarted by frame sync at each clock rise
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_d    <= 1'b0;
      tick_d   <= 1'b0;
      hw_count <= 10'h000;
    end else begin
      clk_d <= clk_s;
      tick_d <= tick;
      if (tick) begin
        hw_count <= count_now;
      end
    end
  end

  // Walkers over the highway lists
  wire [4:0] tx_ptr;
  wire [4:0] tx_pipe;
  wire       tx_strobe;
  wire [7:0] tx_idx;
  wire [4:0] rxw_ptr;
  wire [4:0] rxw_pipe;
  wire       rx_strobe;
  wire [7:0] rx_idx;
  wire       rx_last;
  wire tx_ok = out_ok[tx_ptr] && out_if[tx_ptr] == `TSLM_IF_HIGHWAY;
  wire rx_ok = in_ok[rxw_ptr] && in_if[rxw_ptr] == `TSLM_IF_HIGHWAY;

  tslm_slot_walker u_tx_walk (
    .hclk(hclk), .hresetn(hresetn), .tick(tick), .count(count_now),
    .desc(out_desc[tx_ptr]), .desc_ok(tx_ok), .ptr(tx_ptr), .slot_pipe(tx_pipe),
    .strobe(tx_strobe), .idx(tx_idx), .last()
  );

  tslm_slot_walker u_rx_walk (
    .hclk(hclk), .hresetn(hresetn), .tick(tick), .count(count_now),
    .desc(in_desc[rxw_ptr]), .desc_ok(rx_ok), .ptr(rxw_ptr), .slot_pipe(rxw_pipe),
    .strobe(rx_strobe), .idx(rx_idx), .last(rx_last)
  );

  // Monitor field is meaningful only in monitor and noncontiguous modes
  function [4:0] mon_field;
    input [31:0] d;
    input [4:0]  own;
    begin
      if (d[`TSLM_MODE_HI:`TSLM_MODE_LO] == `TSLM_MODE_MONITOR ||
          d[`TSLM_MODE_HI:`TSLM_MODE_LO] == `TSLM_MODE_NONCONT) begin
        mon_field = d[`TSLM_MON_HI:`TSLM_MON_LO];
      end else begin
        mon_field = own;
      end
    end
  endfunction

  // Bits of fixed data used by an outgoing slot
  function [7:0] fixed_width;
    input [31:0] d;
    input [1:0]  ifc;
    begin
      if (d[`TSLM_START_HI:`TSLM_START_LO] == `TSLM_SQ_START && ifc == `TSLM_IF_TERMINAL) begin
        fixed_width = `TSLM_S_WIDTH;
      end else if (d[`TSLM_START_HI:`TSLM_START_LO] == `TSLM_SQ_START &&
                   ifc == `TSLM_IF_NETWORK) begin
        fixed_width = `TSLM_Q_WIDTH_BITS;
      end else begin
        fixed_width = d[`TSLM_BITS_HI:`TSLM_BITS_LO];
      end
    end
  endfunction

  // Transmit source: noncontiguous segments send the target pipe's data
  wire [31:0] tx_desc  = out_desc[tx_pipe];
  wire [4:0]  tx_src   = (tx_desc[`TSLM_MODE_HI:`TSLM_MODE_LO] == `TSLM_MODE_NONCONT) ?
                         tx_desc[`TSLM_MON_HI:`TSLM_MON_LO] : tx_pipe;
  wire [31:0] tx_word  = tx_src[`TSLM_SHORT_BIT] ? fixed_data[tx_src[3:0]] : 32'h00000000;
  wire        tx_in_w  = tx_idx < fixed_width(tx_desc, `TSLM_IF_HIGHWAY) && tx_idx < 8'h20;
  wire        tx_bit   = (tx_in_w ? tx_word[tx_idx[4:0]] : 1'b0) ^ tx_desc[`TSLM_INV_BIT];

  // Highway transmit: one bit per marked clock, low bit first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      highway_tx_data <= 1'b0;
      highway_tx_oe   <= 1'b0;
    end else if (tx_strobe) begin
      highway_tx_data <= tx_bit;
      highway_tx_oe   <= 1'b1;
    end else if (tick_d) begin
      // Strobe trails its tick by one cycle, so a slot bit is judged a cycle late
      highway_tx_oe   <= 1'b0;
    end
  end

  // Receive: gather slot bits and hand the word to its pipe(s)
  wire [31:0] rx_desc = in_desc[rxw_pipe];
  wire [2:0]  rx_mode = rx_desc[`TSLM_MODE_HI:`TSLM_MODE_LO];
  wire        rx_bit  = rxd_s ^ rx_desc[`TSLM_INV_BIT];
  reg  [31:0] rx_acc;        // Bits gathered so far
  reg  [31:0] next_rx_acc;   // Gathered bits with the current one placed
  always @* begin
    next_rx_acc = rx_acc;
    if (rx_idx < 8'h20) begin
      next_rx_acc[rx_idx[4:0]] = rx_bit;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_acc       <= 32'h00000000;
      rx_valid     <= 1'b0;
      rx_word      <= 32'h00000000;
      rx_pipe      <= 5'h00;
      rx_mon_valid <= 1'b0;
      rx_mon_pipe  <= 5'h00;
    end else begin
      rx_valid     <= 1'b0;
      rx_mon_valid <= 1'b0;
      if (rx_strobe) begin
        rx_acc <= (rx_idx == 8'h00) ? {31'h00000000, rx_bit} : next_rx_acc;
        if (rx_last) begin
          rx_valid <= 1'b1;
          rx_word  <= (rx_idx == 8'h00) ? {31'h00000000, rx_bit} : next_rx_acc;
          // Noncontiguous segment delivered as its target pipe
          rx_pipe  <= (rx_mode == `TSLM_MODE_NONCONT) ? mon_field(rx_desc, rxw_pipe) : rxw_pipe;
          // Monitor tap copies the slot to a second pipe
          if (rx_mode == `TSLM_MODE_MONITOR && mon_on[rxw_pipe]) begin
            rx_mon_valid <= 1'b1;
            rx_mon_pipe  <= mon_field(rx_desc, rxw_pipe);
          end
        end
      end
    end
  end

  // Command decode from the write data and the latched arguments
  wire        cmd_go   = wr_pend && ph_addr == `TSLM_CMD_WORD;
  wire [3:0]  opc      = hwdata[`TSLM_OPC_HI:`TSLM_OPC_LO];
  wire        in_v     = hwdata[`TSLM_IN_VALID_BIT];
  wire        out_v    = hwdata[`TSLM_OUT_VALID_BIT];
  wire        ins      = hwdata[`TSLM_INS_BIT];
  wire [4:0]  prev_in  = hwdata[`TSLM_PREV_IN_HI:`TSLM_PREV_IN_LO];
  wire [4:0]  prev_out = hwdata[`TSLM_PREV_OUT_HI:`TSLM_PREV_OUT_LO];
  wire [4:0]  pipe     = hwdata[`TSLM_PIPE_HI:`TSLM_PIPE_LO];
  wire [2:0]  in_mode  = arg_in[`TSLM_MODE_HI:`TSLM_MODE_LO];
  wire [2:0]  out_mode = arg_out[`TSLM_MODE_HI:`TSLM_MODE_LO];
  // Reserved modes refused; monitor refused on outgoing entries
  wire in_bad  = in_v && ins && (in_mode == 3'h1 || in_mode == 3'h4 || in_mode == 3'h5 ||
                                 in_mode == 3'h6);
  wire out_bad = out_v && ins && (out_mode == 3'h1 || out_mode == 3'h4 || out_mode == 3'h5 ||
                                  out_mode == 3'h6 || out_mode == `TSLM_MODE_MONITOR);
  wire def_ok  = opc == `TSLM_OPC_DEFINE && !in_bad && !out_bad;
  wire fix_ok  = opc == `TSLM_OPC_FIXED && pipe[`TSLM_SHORT_BIT];

  // List store and command execution
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 32; i = i + 1) begin
        in_desc[i]  <= 32'h00000000;
        out_desc[i] <= 32'h00000000;
        in_if[i]    <= 2'h0;
        out_if[i]   <= 2'h0;
      end
      for (i = 0; i < 16; i = i + 1) begin
        fixed_data[i] <= 32'h00000000;
      end
      in_ok    <= 32'h00000000;
      out_ok   <= 32'h00000000;
      mon_on   <= 32'h00000000;
      cmd_cnt  <= 8'h00;
      rej_cnt  <= 8'h00;
      last_rej <= 1'b0;
    end else if (cmd_go) begin
      cmd_cnt  <= cmd_cnt + 8'h01;
      last_rej <= !(def_ok || fix_ok);
      if (!(def_ok || fix_ok)) begin
        rej_cnt <= rej_cnt + 8'h01;
      end
      // Define: act only on flagged directions
      if (def_ok && in_v) begin
        if (ins) begin
          // Splice after the previous entry; lone entry keeps its own link
          if (prev_in != pipe) begin
            in_desc[prev_in][`TSLM_NEXT_HI:`TSLM_NEXT_LO] <= pipe;
          end
          in_desc[pipe] <= arg_in;
          in_if[pipe]   <= if_sel;
          in_ok[pipe]   <= 1'b1;
          mon_on[pipe]  <= in_mode == `TSLM_MODE_MONITOR;
        end else begin
          // Delete ignores the argument and unlinks monitor link goes too
          in_desc[prev_in][`TSLM_NEXT_HI:`TSLM_NEXT_LO] <=
            in_desc[pipe][`TSLM_NEXT_HI:`TSLM_NEXT_LO];
          in_ok[pipe]  <= 1'b0;
          mon_on[pipe] <= 1'b0;
        end
      end
      if (def_ok && out_v) begin
        if (ins) begin
          if (prev_out != pipe) begin
            out_desc[prev_out][`TSLM_NEXT_HI:`TSLM_NEXT_LO] <= pipe;
          end
          out_desc[pipe] <= arg_out;
          out_if[pipe]   <= if_sel;
          out_ok[pipe]   <= 1'b1;
        end else begin
          out_desc[prev_out][`TSLM_NEXT_HI:`TSLM_NEXT_LO] <=
            out_desc[pipe][`TSLM_NEXT_HI:`TSLM_NEXT_LO];
          out_ok[pipe] <= 1'b0;
        end
      end
      // Fixed data for a short pipe, low bit sent first
      if (fix_ok) begin
        fixed_data[pipe[3:0]] <= arg_out;
      end
    end
  end

  // AHB-Lite address and data phases; reads take one wait state
  wire       take  = hsel && htrans[1] && hready;
  wire [31:0] q_in  = in_desc[query];
  wire [31:0] q_out = out_desc[query];
  reg  [31:0] next_rdata; // Read value of the latched address

  always @* begin
    case (ph_addr)
      `TSLM_ARG_IN:   next_rdata = arg_in;
      `TSLM_ARG_OUT:  next_rdata = arg_out;
      `TSLM_IF_SEL:   next_rdata = {30'h00000000, if_sel};
      `TSLM_STATUS:   next_rdata = {15'h0000, last_rej, rej_cnt, cmd_cnt};
      `TSLM_QUERY:    next_rdata = {27'h0000000, query};
      `TSLM_Q_IN:     next_rdata = q_in;
      `TSLM_Q_OUT:    next_rdata = q_out;
      `TSLM_Q_FLAGS:  next_rdata = {25'h0000000, out_if[query], in_if[query],
                                    mon_on[query], out_ok[query], in_ok[query]};
      `TSLM_Q_FIXED:  next_rdata = query[`TSLM_SHORT_BIT] ? fixed_data[query[3:0]] :
                                   32'h00000000;
      `TSLM_Q_WIDTH:  next_rdata = {24'h000000, fixed_width(q_out, out_if[query])};
      `TSLM_HW_COUNT: next_rdata = {22'h000000, hw_count};
      default:        next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      ph_addr   <= 8'h00;
      arg_in    <= 32'h00000000;
      arg_out   <= 32'h00000000;
      if_sel    <= `TSLM_IF_HIGHWAY;
      query     <= 5'h00;
    end else begin
      hresp <= 1'b0;
      // Write data phase stores plain registers
      if (wr_pend) begin
        case (ph_addr)
          `TSLM_ARG_IN:  arg_in  <= hwdata;
          `TSLM_ARG_OUT: arg_out <= hwdata;
          `TSLM_IF_SEL:  if_sel  <= hwdata[1:0];
          `TSLM_QUERY:   query   <= hwdata[4:0];
          default:       ;
        endcase
      end
      if (rd_pend) begin
        // Second read cycle: answer from settled state
        hrdata    <= next_rdata;
        hreadyout <= 1'b1;
        rd_pend   <= 1'b0;
        wr_pend   <= 1'b0;
      end else if (take) begin
        ph_addr   <= {haddr[7:2], 2'b00};
        wr_pend   <= hwrite;
        rd_pend   <= !hwrite;
        hreadyout <= hwrite;
      end else if (hready) begin
        wr_pend <= 1'b0;
      end
    end
  end

endmodule

// *** logic/tslm_consts.vh ***
// Constants for the time-slot list manager: register map, field positions, codes
`ifndef TSLM_CONSTS_VH
`define TSLM_CONSTS_VH

// Register byte offsets
`define TSLM_CMD_WORD      8'h00
`define TSLM_ARG_IN        8'h04
`define TSLM_ARG_OUT       8'h08
`define TSLM_IF_SEL        8'h0c
`define TSLM_STATUS        8'h10
`define TSLM_QUERY         8'h14
`define TSLM_Q_IN          8'h18
`define TSLM_Q_OUT         8'h1c
`define TSLM_Q_FLAGS       8'h20
`define TSLM_Q_FIXED       8'h24
`define TSLM_Q_WIDTH       8'h28
`define TSLM_HW_COUNT      8'h2c

// Command word fields
`define TSLM_OPC_HI        31
`define TSLM_OPC_LO        28
`define TSLM_OPC_DEFINE    4'h7
`define TSLM_OPC_FIXED     4'h8
`define TSLM_IN_VALID_BIT  17
`define TSLM_OUT_VALID_BIT 16
`define TSLM_INS_BIT       15
`define TSLM_PREV_IN_HI    14
`define TSLM_PREV_IN_LO    10
`define TSLM_PREV_OUT_HI   9
`define TSLM_PREV_OUT_LO   5
`define TSLM_PIPE_HI       4
`define TSLM_PIPE_LO       0
`define TSLM_SHORT_BIT     4

// Descriptor fields
`define TSLM_BITS_HI       31
`define TSLM_BITS_LO       24
`define TSLM_START_HI      23
`define TSLM_START_LO      14
`define TSLM_INV_BIT       13
`define TSLM_MODE_HI       12
`define TSLM_MODE_LO       10
`define TSLM_MON_HI        9
`define TSLM_MON_LO        5
`define TSLM_NEXT_HI       4
`define TSLM_NEXT_LO       0

// Slot modes
`define TSLM_MODE_NORMAL   3'h0
`define TSLM_MODE_MONITOR  3'h2
`define TSLM_MODE_NONCONT  3'h3
`define TSLM_MODE_ANCHOR   3'h7

// Interface codes for list membership
`define TSLM_IF_HIGHWAY    2'h0
`define TSLM_IF_TERMINAL   2'h1
`define TSLM_IF_NETWORK    2'h2

// Fixed pipes and widths
`define TSLM_ANCHOR_PIPE   5'h10
`define TSLM_SQ_START      10'h010
`define TSLM_S_WIDTH       8'h14
`define TSLM_Q_WIDTH_BITS  8'h05

`endif

// *** logic/tslm_sync.v ***
// Two flip-flop synchroniser for one level from outside the clock domain
module tslm_sync (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Level in and synchronised level out
  input  wire din,
  output reg  dout
);

  reg meta; // First stage, read only by the second

  // Two stage capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// *** logic/tslm_slot_walker.v ***
// Walks one circular slot list and marks each bit of each live slot
`include "tslm_consts.vh"
module tslm_slot_walker (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Highway timing
  input  wire       tick,
  input  wire [9:0] count,
  // Current descriptor as seen at ptr
  input  wire [31:0] desc,
  input  wire       desc_ok,
  // List walk position and slot bit marks
  output reg  [4:0] ptr,
  output reg  [4:0] slot_pipe,
  output reg        strobe,
  output reg  [7:0] idx,
  output reg        last
);

  reg        active;  // Inside a slot
  reg  [7:0] done;    // Bits already handled in this slot
  wire [7:0] nbits = desc[`TSLM_BITS_HI:`TSLM_BITS_LO];
  wire [9:0] start = desc[`TSLM_START_HI:`TSLM_START_LO];
  wire [2:0] mode  = desc[`TSLM_MODE_HI:`TSLM_MODE_LO];
  wire [4:0] next  = desc[`TSLM_NEXT_HI:`TSLM_NEXT_LO];
  // Only normal, monitor and noncontiguous carry bits
  wire usable = desc_ok && (mode == `TSLM_MODE_NORMAL || mode == `TSLM_MODE_MONITOR ||
                            mode == `TSLM_MODE_NONCONT);
  wire [7:0] cur = active ? done : 8'h00;

  // Walk the list and time each slot
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr       <= `TSLM_ANCHOR_PIPE;
      slot_pipe <= 5'h00;
      strobe    <= 1'b0;
      idx       <= 8'h00;
      last      <= 1'b0;
      active    <= 1'b0;
      done      <= 8'h00;
    end else begin
      strobe <= 1'b0;
      last   <= 1'b0;
      if (!desc_ok) begin
        // Entry gone: restart at the list head
        ptr    <= `TSLM_ANCHOR_PIPE;
        active <= 1'b0;
      end else if (!active && !usable) begin
        // Anchor and reserved entries carry no slot; step past them
        ptr <= next;
      end else if (tick && (active || (count == start && nbits != 8'h00))) begin
        // Slot begins at its start count and lasts nbits bits
        strobe    <= 1'b1;
        idx       <= cur;
        slot_pipe <= ptr;
        if (cur + 8'h01 == nbits) begin
          active <= 1'b0;
          last   <= 1'b1;
          ptr    <= next;
        end else begin
          active <= 1'b1;
          done   <= cur + 8'h01;
        end
      end
    end
  end

endmodule

// *** tb/tslm_top_assertions.sv ***
// Checker for bus timing and slot outputs of the slot list manager
`include "tslm_consts.vh"
module tslm_top_assertions (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Slot outputs
  input wire logic        highway_tx_oe,
  input wire logic        rx_valid,
  input wire logic [4:0]  rx_pipe,
  input wire logic        rx_mon_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Accepted bus request
  wire take = hsel & htrans[1] & hready;
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  chk_write_zero: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  chk_rx_pulse: assert property (rx_valid |=> !rx_valid [*6])
    else $error("slot word pulses too close");
  chk_mon_pair: assert property (rx_mon_valid |-> rx_valid)
    else $error("monitor copy without slot word");
  chk_anchor_quiet: assert property (rx_valid |-> rx_pipe != `TSLM_ANCHOR_PIPE)
    else $error("anchor pipe carried a slot");
  chk_tx_hold: assert property ($rose(highway_tx_oe) |=> highway_tx_oe [*6])
    else $error("transmit bit shorter than a bit clock");
endmodule

// *** tb/tslm_hw_model.sv ***
// Highway far side: bit clock, frame sync and receive data, one frame per request
module tslm_hw_model (
  // Frame request and receive pattern
  input  wire logic        go,
  input  wire logic [31:0] pat,
  // Highway pins
  output logic             bclk,
  output logic             fsync,
  output logic             rxd,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  initial begin
    bclk = 0;
    fsync = 0;
    rxd = 0;
    busy = 0;
  end
  // Slots follow in frame order from count 0; the clock stands still between frames
  always @(posedge go) begin
    busy = 1;
    #10;  // Keep every pin change clear of the bench clock edges
    for (k = 0; k < 24; k++) begin
      #100;
      rxd = pat[k];      // Bit for count k, held across its rise
      fsync = (k == 0);  // Sync marks count 0
      #100 bclk = 1;
      #200 bclk = 0;
    end
    fsync = 0;
    rxd = ~rxd;  // Released line shows no stale level
    busy = 0;
  end
endmodule

// *** tb/tb_tslm_top.sv ***
// Self-checking bench for the slot list manager
`include "tslm_consts.vh"
`define CK(nm, e, g) tests_run++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end
module tb_tslm_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, go;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rx_word, pat, rs, q, fx, txw;
  logic        hreadyout, hresp, bclk, fsync, rxd, tx, oe, rx_valid, rx_mon_valid, busy, inv;
  logic [4:0]  rx_pipe, rx_mon_pipe;
  logic [7:0]  slot_w;
  int          n_fail, tests_run, i, n, nb, first;
  tslm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .highway_bit_clock(bclk), .highway_frame_sync(fsync),
    .highway_rx_data(rxd), .highway_tx_data(tx), .highway_tx_oe(oe), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_pipe(rx_pipe), .rx_mon_valid(rx_mon_valid), .rx_mon_pipe(rx_mon_pipe));
  tslm_hw_model u_hw (.go(go), .pat(pat), .bclk(bclk), .fsync(fsync), .rxd(rxd), .busy(busy));
  initial begin
    hclk = 0;
    forever #25 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Descriptor and define-slot command words
  function automatic logic [31:0] dsc(input logic [7:0] l, input logic [9:0] s, input logic v,
                                     input logic [2:0] m, input logic [4:0] mon, nx);
    return {l, s, v, m, mon, nx};
  endfunction
  function automatic logic [31:0] cmd(input logic iv, ov, ins, input logic [4:0] pi, po, p);
    return {4'h7, 10'h0, iv, ov, ins, pi, po, p};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One AHB-Lite single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int k;
    k = 0;
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 99);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 99);
    r = hrdata;
    if (k >= 99) begin
      n_fail++;
      close_out;
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask
  // Wait a bounded time for a level; a timeout ends the run
  task automatic hold_for(input bit want_rx);
    n = 0;
    while ((want_rx ? rx_valid !== 1'b1 : busy) && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 2000) begin
      n_fail++;
      close_out;
    end
  endtask
  // Collect transmitted slot bits at each bit clock rise
  always @(posedge bclk) begin
    if (oe === 1'b1) begin
      if (nb == 0) first = u_hw.k;
      txw[nb[4:0]] = tx;
      nb++;
    end
  end
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    go = 0; pat = 0; rs = 32'hdd45ccf8; n_fail = 0; tests_run = 0; nb = 0; txw = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd(`TSLM_STATUS); `CK("status", 32'h0, q)
    rd(32'h30); `CK("unmapped", 32'h0, q)
    // Anchor with junk length and start, self-linked
    wr(`TSLM_ARG_IN, dsc(8'hff, 10'h3ff, 1'b1, `TSLM_MODE_ANCHOR, 5'h0, 5'h10));
    wr(`TSLM_ARG_OUT, dsc(8'h5a, 10'h2, 1'b1, `TSLM_MODE_ANCHOR, 5'h0, 5'h10));
    wr(`TSLM_CMD_WORD, cmd(1, 1, 1, 5'h10, 5'h10, 5'h10));
    wr(`TSLM_ARG_IN, dsc(8'h4, 10'h9, 1'b0, `TSLM_MODE_MONITOR, 5'h14, 5'h10));
    wr(`TSLM_CMD_WORD, cmd(1, 0, 1, 5'h10, 5'h0, 5'h12));
    for (i = 0; i < 3; i++) begin
      rs = lfsr(rs);
      slot_w = (i == 0) ? 8'h8 : {5'h0, rs[2:0]} + 8'h1;
      inv = rs[3];
      wr(`TSLM_ARG_OUT, dsc(slot_w, 10'h5, inv, `TSLM_MODE_NORMAL, 5'h0, 5'h10));
      wr(`TSLM_CMD_WORD, cmd(0, 1, 1, 5'h0, 5'h10, 5'h11));
      rs = lfsr(rs);
      fx = rs;
      wr(`TSLM_ARG_OUT, fx);
      wr(`TSLM_CMD_WORD, {4'h8, 23'h0, 5'h11});
      rs = lfsr(rs);
      pat <= rs;
      nb = 0;
      txw = 0;
      go <= 1;
      @(posedge hclk);
      go <= 0;
      hold_for(1);
      `CK("rx word", {28'h0, pat[12:9]}, rx_word)
      `CK("rx pipe", 5'h12, rx_pipe)
      `CK("mon valid", 1'b1, rx_mon_valid)
      `CK("mon pipe", 5'h14, rx_mon_pipe)
      hold_for(0);
      `CK("tx bits", int'(slot_w), nb)
      `CK("tx start", 6, first)
      `CK("tx data", (fx ^ {32{inv}}) & ((32'h1 << slot_w) - 32'h1), txw)
    end
    wr(`TSLM_QUERY, 32'h11);
    rd(`TSLM_Q_FIXED); `CK("fixed", fx, q)
    rd(`TSLM_Q_WIDTH); `CK("width", {24'h0, slot_w}, q)
    rd(`TSLM_Q_FLAGS); `CK("flags", 2'h2, q[1:0])
    // Delete the monitored slot with junk contents
    rs = lfsr(rs);
    wr(`TSLM_ARG_IN, rs);
    wr(`TSLM_CMD_WORD, cmd(1, 0, 0, 5'h10, 5'h0, 5'h12));
    wr(`TSLM_QUERY, 32'h12);
    rd(`TSLM_Q_FLAGS); `CK("mon link", 1'b0, q[2])
    `CK("in ok", 1'b0, q[0])
    // Noncontiguous receive segment on a sacrificial pipe, delivered to its target
    wr(`TSLM_ARG_IN, dsc(8'h4, 10'h9, 1'b0, `TSLM_MODE_NONCONT, 5'h15, 5'h10));
    wr(`TSLM_CMD_WORD, cmd(1, 0, 1, 5'h10, 5'h0, 5'h13));
    rs = lfsr(rs);
    pat <= rs;
    go <= 1;
    @(posedge hclk);
    go <= 0;
    hold_for(1);
    `CK("seg word", {28'h0, pat[12:9]}, rx_word)
    `CK("seg pipe", 5'h15, rx_pipe)
    `CK("seg no mon", 1'b0, rx_mon_valid)
    hold_for(0);
    // Reserved modes, outgoing monitor and long-pipe fixed data are refused
    for (i = 0; i < 5; i++) begin
      wr(`TSLM_ARG_OUT, dsc(8'h1, 10'h5, 1'b0,
                            (i == 0) ? 3'h1 : (i == 4) ? 3'h2 : 3'(i + 3), 5'h14, 5'h10));
      wr(`TSLM_CMD_WORD, cmd(0, 1, 1, 5'h0, 5'h10, 5'h13));
      rd(`TSLM_STATUS); `CK("refused", 1'b1, q[16])
    end
    wr(`TSLM_CMD_WORD, {4'h8, 23'h0, 5'h5});
    rd(`TSLM_STATUS); `CK("refusals", 8'h6, q[15:8])
    // Rate-interface widths for the S and Q positions
    for (i = 1; i < 3; i++) begin
      wr(`TSLM_IF_SEL, i);
      wr(`TSLM_ARG_OUT, dsc(8'h1, 10'h10, 1'b0, `TSLM_MODE_NORMAL, 5'h0, 5'(i)));
      wr(`TSLM_CMD_WORD, cmd(0, 1, 1, 5'h0, 5'(i), 5'(i)));
      wr(`TSLM_QUERY, i);
      rd(`TSLM_Q_WIDTH); `CK("rate width", (i == 1) ? 32'h14 : 32'h5, q)
    end
    close_out;
  end
endmodule
bind tslm_top tslm_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .highway_tx_oe(highway_tx_oe), .rx_valid(rx_valid), .rx_pipe(rx_pipe),
  .rx_mon_valid(rx_mon_valid));
